// ### spd_regs.svh
// constants of the bank-switched eeprom serial front end
// assumes REF_CLK at 25 MHz; counts are derived from the clock rate
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

// control codes, upper nibble of the control byte
`define SPD_CODE_ARRAY   4'hA
`define SPD_CODE_PROT    4'h6

// bank command chip-select prefix, 11x
`define SPD_BANK_PFX     2'h3

// geometry
`define SPD_MEM_BYTES    512
`define SPD_PAGE_BYTES   16
`define SPD_ERASED       8'hFF

// timing, times in ms as printed, clock in kHz
`define SPD_CLK_KHZ      25000
`define SPD_TWC_MS       5
`define SPD_TOUT_MS      30
`define SPD_TWC_CYC      (`SPD_TWC_MS * `SPD_CLK_KHZ)
`define SPD_TOUT_CYC     (`SPD_TOUT_MS * `SPD_CLK_KHZ)
`define SPD_TWC_W        17
`define SPD_TOUT_W       20

`endif

// ### spd_pkg.sv
// types shared by the eeprom front end and its link capture
// assumes spd_regs.svh supplies the sizes
`include "spd_regs.svh"
`default_nettype none

package spd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_DUMMY
  } spd_state_t;

  // state of the link capture, clocked by SCL
  typedef struct packed {
    logic tog;
    logic bit_val;
  } spd_link_t;

  // open-drain data pin drive
  typedef struct packed {
    logic out;
    logic oe;
  } spd_pin_t;

  // whole state of the core, clocked by REF_CLK
  typedef struct packed {
    logic [1:0]                                  scl_sy;
    logic [1:0]                                  sda_sy;
    logic                                        scl_d;
    logic                                        sda_d;
    logic [3:0]                                  tog_sy;
    logic [1:0]                                  bit_sy;
    logic [6:0]                                  strap_m;
    logic [6:0]                                  strap_s;
    spd_state_t                                  st;
    logic [3:0]                                  cnt;
    logic [7:0]                                  shr;
    logic                                        ack_pend;
    logic                                        rd_mode;
    logic                                        dirty;
    logic                                        bank;
    spd_pin_t                                    pin;
    logic [7:0]                                  ptr;
    logic [7:0]                                  txb;
    logic [4:0]                                  wpage;
    logic [`SPD_TOUT_W-1:0]                      tout;
    logic [`SPD_TWC_W-1:0]                       wcnt;
    logic                                        busy;
    logic [`SPD_PAGE_BYTES-1:0][7:0]             pbuf;
    logic [`SPD_MEM_BYTES-1:0][7:0]              mem;
  } spd_core_t;

endpackage

`default_nettype wire

// ### spd_link_cap.sv
// link capture: samples the data line on each serial clock rise
// assumes scl is the bus clock; it stands still between frames and during reset
`default_nettype none

module spd_link_cap
  import spd_pkg::*;
(
  // reset, held while the bus clock stands still
  input  wire logic      rst,
  // link side
  input  wire logic      scl,
  input  wire logic      sda_in,
  // toward the core domain
  output var  spd_link_t cap
);

  spd_link_t r;
  spd_link_t n;

  // each flip of the toggle tells the core a new bit was taken
  always_comb
  begin
    n         = r;
    n.tog     = ~r.tog;
    n.bit_val = sda_in; // RULE4
  end

  // async clear: scl has no edges during reset, so release is safe
  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign cap = r;

endmodule

`default_nettype wire

// ### spd_eeprom_core.sv
// serial slave front end of a two-bank 512-byte eeprom
// assumes REF_CLK 25 MHz, SYS_RST synchronous; SCL, SDA and straps are async pins
//
// What this block does
// RULE1: idle bus has both lines high
// RULE2: SDA falling while SCL high is start
// RULE3: SDA rising while SCL high is stop
// RULE4: one bit per SCL pulse, stable high
// RULE5: overlong page write keeps last sixteen bytes
// RULE6: acknowledge every received byte when addressed
// RULE7: acknowledge holds SDA low through high phase
// RULE8: no acknowledge while write cycle runs
// RULE9: master nack ends read; release SDA
// RULE10: SCL low too long resets interface
// RULE11: control code 1010 array, 0110 bank
// RULE12: array commands need chip-select pin match
// RULE13: control byte bit zero is direction
// RULE14: bank commands skip chip-select compare
// RULE15: bank selector volatile, zero after reset
// RULE16: two 256-byte banks, 000h and 100h
// RULE17: sequential read wraps inside its bank
// RULE18: bank set acks control, not dummies
// RULE19: bank read acks only for bank zero
// RULE20: byte write: control, address, data, stop
// RULE21: protected write: no ack, no write
// RULE22: page write increments low four bits
// RULE23: write cycle finishes within 5 ms
// RULE24: pointer advances after every access
// RULE25: timeout counts SCL low, 25-35 ms
// RULE26: short page write rewrites whole page
`include "spd_regs.svh"
`default_nettype none

module spd_eeprom_core
  import spd_pkg::*;
#(
  parameter int unsigned WR_CYC   = `SPD_TWC_CYC,
  parameter int unsigned TOUT_CYC = `SPD_TOUT_CYC
)
(
  // system
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  // serial bus
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output var  logic       SDA_OUT,
  output var  logic       SDA_OE,
  // straps
  input  wire logic [2:0] CHIP_ADDR,
  input  wire logic [3:0] PROT_BLK,
  // status
  output var  logic       BANK_SEL,
  output var  logic       WRITE_BUSY
);

  spd_core_t r;
  spd_core_t n;
  spd_link_t cap;

  // bits are taken in the SCL domain; only a toggle and the bit cross over
  spd_link_cap u_link
  (
    .rst    (SYS_RST),
    .scl    (SCL_IN),
    .sda_in (SDA_IN),
    .cap    (cap)
  );

  always_comb
  begin
    logic       scl;
    logic       sda;
    logic       start_ev;
    logic       stop_ev;
    logic       fall_ev;
    logic       bit_ev;
    logic       bv;
    logic [7:0] byte_in;
    logic [2:0] chip;
    logic [3:0] prot;
    logic [1:0] blk;
    logic       is_array;
    logic       is_bank;

    scl      = r.scl_sy[1];
    sda      = r.sda_sy[1];
    start_ev = 1'b0;
    stop_ev  = 1'b0;
    fall_ev  = 1'b0;
    bit_ev   = 1'b0;
    bv       = r.bit_sy[1];
    byte_in  = {r.shr[6:0], r.bit_sy[1]};
    chip     = r.strap_s[2:0];
    prot     = r.strap_s[6:3];
    blk      = {r.bank, r.ptr[7]};
    is_array = (byte_in[7:4] == `SPD_CODE_ARRAY) && (byte_in[3:1] == chip); // RULE11 RULE12
    is_bank  = (byte_in[7:4] == `SPD_CODE_PROT) && (byte_in[3:2] == `SPD_BANK_PFX); // RULE11 RULE14
    n        = r;

    // two-flop synchronisers, four flops for the toggle; first stage read only by the second
    n.scl_sy  = {r.scl_sy[0], SCL_IN};
    n.sda_sy  = {r.sda_sy[0], SDA_IN};
    n.tog_sy  = {r.tog_sy[2:0], cap.tog};
    n.bit_sy  = {r.bit_sy[0], cap.bit_val};
    n.strap_m = {PROT_BLK, CHIP_ADDR};
    n.strap_s = r.strap_m;
    n.scl_d   = scl;
    n.sda_d   = sda;

    start_ev = scl & r.scl_d & r.sda_d & ~sda; // RULE2
    stop_ev  = scl & r.scl_d & ~r.sda_d & sda; // RULE3
    fall_ev  = r.scl_d & ~scl;
    // toggle seen one stage after the bit copy, so the bit copy has settled
    bit_ev   = r.tog_sy[2] ^ r.tog_sy[3]; // RULE4

    // self-timed write cycle; page buffer lands in one go
    if (r.busy)
    begin
      if (r.wcnt == `SPD_TWC_W'(WR_CYC - 1)) // RULE23
      begin
        n.busy = 1'b0;
        n.wcnt = '0;
        for (int i = 0; i < `SPD_PAGE_BYTES; i++)
        begin
          n.mem[{r.wpage, 4'(i)}] = r.pbuf[i]; // RULE26
        end
      end
      else
      begin
        n.wcnt = r.wcnt + 1'b1;
      end
    end

    // bit slots 0..7 carry data, slot 8 is the acknowledge
    if (bit_ev && r.st != ST_IDLE)
    begin
      if (r.cnt != 4'h8)
      begin
        n.shr = byte_in;
        n.cnt = r.cnt + 1'b1;
      end
      else
      begin
        n.cnt      = '0;
        n.ack_pend = 1'b0;
        if (r.st == ST_RDATA)
        begin
          // first slot after the control byte is our own acknowledge
          if (!r.rd_mode)
          begin
            n.rd_mode = 1'b1;
          end
          else if (bv)
          begin
            n.st      = ST_IDLE; // RULE9
            n.rd_mode = 1'b0;
          end
          else
          begin
            n.txb = r.mem[{r.bank, r.ptr}];
            n.ptr = r.ptr + 1'b1; // RULE17 RULE24
          end
        end
      end

      // a whole byte has arrived
      if (r.cnt == 4'h7)
      begin
        case (r.st)
          ST_CTRL:
          begin
            if (r.busy)
            begin
              n.st = ST_IDLE; // RULE8
            end
            else if (is_array) // RULE12
            begin
              n.ack_pend = 1'b1; // RULE6
              if (byte_in[0]) // RULE13
              begin
                n.st      = ST_RDATA;
                n.rd_mode = 1'b0;
                n.txb     = r.mem[{r.bank, r.ptr}]; // RULE16
                n.ptr     = r.ptr + 1'b1; // RULE24
              end
              else
              begin
                n.st = ST_ADDR;
              end
            end
            else if (is_bank) // RULE14
            begin
              if (!byte_in[0])
              begin
                n.bank     = byte_in[1]; // RULE15
                n.ack_pend = 1'b1; // RULE18
                n.st       = ST_DUMMY;
              end
              else if (!byte_in[1])
              begin
                n.ack_pend = ~r.bank; // RULE19
                n.st       = ST_DUMMY;
              end
              else
              begin
                n.st = ST_IDLE;
              end
            end
            else
            begin
              n.st = ST_IDLE;
            end
          end
          ST_ADDR:
          begin
            // preload the page so a short write leaves the rest intact
            n.ptr      = byte_in; // RULE20
            n.wpage    = {r.bank, byte_in[7:4]};
            n.pbuf     = r.mem[{r.bank, byte_in[7:4], 4'h0} +: `SPD_PAGE_BYTES]; // RULE26
            n.ack_pend = 1'b1;
            n.st       = ST_WDATA;
          end
          ST_WDATA:
          begin
            if (prot[blk])
            begin
              // refuse at once, earlier bytes of this page are dropped too
              n.st    = ST_IDLE; // RULE21
              n.dirty = 1'b0;
            end
            else
            begin
              n.pbuf[r.ptr[3:0]] = byte_in; // RULE5
              n.ptr[3:0]         = r.ptr[3:0] + 1'b1; // RULE22
              n.dirty            = 1'b1;
              n.ack_pend         = 1'b1; // RULE6
            end
          end
          default:
          begin
            n.ack_pend = 1'b0; // RULE18
          end
        endcase
      end
    end

    // drive the pin only while SCL is low, so it is steady for the high phase
    if (fall_ev)
    begin
      if (r.st == ST_IDLE)
      begin
        n.pin.oe = 1'b0; // RULE1
      end
      else if (r.busy)
      begin
        n.pin.oe = 1'b0; // RULE8
      end
      else if (n.cnt == 4'h8)
      begin
        n.pin.oe = n.ack_pend; // RULE7
      end
      else if (n.st == ST_RDATA && n.rd_mode)
      begin
        n.pin.oe = ~n.txb[~n.cnt[2:0]];
      end
      else
      begin
        n.pin.oe = 1'b0; // RULE9
      end
    end

    if (start_ev)
    begin
      n.st       = ST_CTRL;
      n.cnt      = '0;
      n.ack_pend = 1'b0;
      n.rd_mode  = 1'b0;
      n.dirty    = 1'b0;
      n.pin.oe   = 1'b0;
    end
    else if (stop_ev)
    begin
      // only a stop commits; a repeated start drops the buffer
      if (r.st == ST_WDATA && r.dirty && !r.busy)
      begin
        n.busy = 1'b1; // RULE20
        n.wcnt = '0;
      end
      n.st      = ST_IDLE;
      n.dirty   = 1'b0;
      n.rd_mode = 1'b0;
      n.pin.oe  = 1'b0; // RULE1
    end

    // SCL-low watchdog, cleared whenever SCL is high
    if (scl || r.st == ST_IDLE)
    begin
      n.tout = '0; // RULE25
    end
    else if (r.tout == `SPD_TOUT_W'(TOUT_CYC - 1))
    begin
      // limitation: a stalled master loses the whole frame
      n.tout    = '0;
      n.st      = ST_IDLE; // RULE10
      n.dirty   = 1'b0;
      n.rd_mode = 1'b0;
      n.pin.oe  = 1'b0;
    end
    else
    begin
      n.tout = r.tout + 1'b1; // RULE25
    end

    // open drain: the pin is only ever pulled low
    n.pin.out = 1'b0;

    if (SYS_RST)
    begin
      n     = '0;
      n.st  = ST_IDLE;
      // pins rest high, so no false edge is seen after reset
      n.scl_sy = 2'h3;
      n.sda_sy = 2'h3;
      n.scl_d  = 1'h1;
      n.sda_d  = 1'h1;
      // flops come up erased; a real array would keep its cells
      n.mem = {`SPD_MEM_BYTES{`SPD_ERASED}}; // RULE15
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    r <= n;
  end

  // outputs straight from the state flops
  assign SDA_OUT    = r.pin.out;
  assign SDA_OE     = r.pin.oe;
  assign BANK_SEL   = r.bank;
  assign WRITE_BUSY = r.busy;

endmodule

`default_nettype wire

// ### spd_core_asserts.sv
// assertions on the eeprom core ports
// assumes one clock domain; bound at the foot
`default_nettype none
module spd_core_asserts
#(
  parameter int unsigned WR_CYC   = 400,
  parameter int unsigned TOUT_CYC = 200
)
(
  // watched ports
  input wire logic       REF_CLK,
  input wire logic       SYS_RST,
  input wire logic       SCL_IN,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic [2:0] CHIP_ADDR,
  input wire logic [3:0] PROT_BLK,
  input wire logic       BANK_SEL,
  input wire logic       WRITE_BUSY
);
  logic [31:0] busy_r;
  logic [31:0] low_r;
  // counters, since long spans cannot be unrolled
  always_ff @(posedge REF_CLK)
  begin
    busy_r <= (SYS_RST || !WRITE_BUSY) ? 32'h0 : busy_r + 32'h1;
    low_r  <= (SYS_RST || SCL_IN) ? 32'h0 : low_r + 32'h1;
  end
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  property p_od;
    !SDA_OUT;
  endproperty
  a_od: assert property (p_od) else $error("sda drive high");
  property p_rst;
    $fell(SYS_RST) |-> !SDA_OE && !BANK_SEL && !WRITE_BUSY;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_busy;
    WRITE_BUSY |-> !SDA_OE;
  endproperty
  a_busy: assert property (p_busy) else $error("ack while busy");
  property p_chg;
    $changed(SDA_OE) |-> !SCL_IN;
  endproperty
  a_chg: assert property (p_chg) else $error("sda moved, scl high");
  property p_hold;
    $rose(SCL_IN) |=> $stable(SDA_OE)[*6];
  endproperty
  a_hold: assert property (p_hold) else $error("sda not held");
  property p_len;
    $fell(WRITE_BUSY) |-> busy_r >= WR_CYC - 1 && busy_r <= WR_CYC + 1;
  endproperty
  a_len: assert property (p_len) else $error("write cycle length");
  property p_max;
    WRITE_BUSY |-> busy_r <= WR_CYC + 1;
  endproperty
  a_max: assert property (p_max) else $error("write cycle overrun");
  property p_tout;
    low_r > TOUT_CYC + 16 |-> !SDA_OE;
  endproperty
  a_tout: assert property (p_tout) else $error("no timeout release");
  property p_go;
    $rose(WRITE_BUSY) |-> SCL_IN && SDA_IN;
  endproperty
  a_go: assert property (p_go) else $error("write not after stop");
endmodule

bind spd_eeprom_core spd_core_asserts #(.WR_CYC(WR_CYC), .TOUT_CYC(TOUT_CYC)) i_chk (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .CHIP_ADDR(CHIP_ADDR), .PROT_BLK(PROT_BLK), .BANK_SEL(BANK_SEL), .WRITE_BUSY(WRITE_BUSY));
`default_nettype wire

// ### spd_bus_master.sv
// two-wire bus master model, it drives the serial clock
// assumes a pull-up on data; sda_in is the wire level
`default_nettype none
module spd_bus_master
#(
  parameter int H = 330
)
(
  // bus
  input  wire logic sda_in,
  output var  logic scl,
  output var  logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: both released, clock stands still
  initial
  begin
    scl = 1'h1;
    sda = 1'h1;
  end
  task automatic start();
    #(H/2) sda = 1'h1;
    #H scl = 1'h1;
    #H sda = 1'h0;
    #H scl = 1'h0;
  endtask
  task automatic stop();
    #(H/2) sda = 1'h0;
    #H scl = 1'h1;
    #H sda = 1'h1;
    #H;
  endtask
  // data moves only in the low phase
  task automatic xfer(input logic b, output logic r);
    #(H/2) sda = b;
    #(H/2) scl = 1'h1;
    #(H/2) r = sda_in;
    #(H/2) scl = 1'h0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer(b[i], r);
    xfer(1'h1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer(1'h1, b[i]);
    xfer(!ack, r);
  endtask
  // slow answer: clock held low
  task automatic hold(input int t);
    #t;
  endtask
endmodule
`default_nettype wire

// ### test_spd_eeprom_i2c_bank_write_ctrl.sv
// self-checking bench for the eeprom serial front end
// assumes the core and the bus master model
`default_nettype none
module test_spd_eeprom_i2c_bank_write_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk   = 1'h0;
  logic       sys_rst   = 1'h0;
  logic [2:0] chip_addr = 3'h5;
  logic [3:0] prot_blk  = 4'h8;
  logic       scl;
  logic       sda_m;
  logic       sda_oe;
  logic       sda_out;
  logic       bank_sel;
  logic       write_busy;
  wire logic  sda_w     = sda_m & !sda_oe;
  int         errors    = 0;
  int         tests_run = 0;
  int         cyc       = 0;
  logic       ack;
  logic [7:0] rd;
  always #20 ref_clk = !ref_clk;
  spd_eeprom_core #(.WR_CYC(400), .TOUT_CYC(200)) i_dut (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .CHIP_ADDR(chip_addr), .PROT_BLK(prot_blk), .BANK_SEL(bank_sel), .WRITE_BUSY(write_busy));
  spd_bus_master i_mst (.sda_in(sda_w), .scl(scl), .sda(sda_m));
  task automatic conclude();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  // hang guard, well past the expected run
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      conclude();
    end
  end
  task automatic cmd(input logic [7:0] b, input logic exp);
    i_mst.wbyte(b, ack);
    chb(ack, exp);
  endtask
  task automatic rdchk(input logic more, input logic [7:0] exp);
    i_mst.rbyte(more, rd);
    chk(rd, exp);
  endtask
  task automatic sel(input logic [7:0] a);
    i_mst.start();
    cmd(8'hAA, 1'h1);
    cmd(a, 1'h1);
    i_mst.start();
    cmd(8'hAB, 1'h1);
  endtask
  task automatic bset(input logic [7:0] c, input logic b);
    i_mst.start();
    cmd(c, 1'h1);
    cmd(8'h00, 1'h0);
    cmd(8'h00, 1'h0);
    i_mst.stop();
    chb(bank_sel, b);
  endtask
  task automatic s_reset();
    sys_rst <= 1'h1;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    repeat (4) @(posedge ref_clk);
    chb(bank_sel, 1'h0);
    chb(write_busy, 1'h0);
  endtask
  task automatic s_page_write();
    i_mst.start();
    cmd(8'hAA, 1'h1);
    cmd(8'h0E, 1'h1);
    cmd(8'h11, 1'h1);
    cmd(8'h22, 1'h1);
    cmd(8'h33, 1'h1);
    i_mst.stop();
    repeat (8) @(posedge ref_clk);
    chb(write_busy, 1'h1);
    i_mst.start();
    cmd(8'hAA, 1'h0);
    repeat (300) @(posedge ref_clk);
    chb(write_busy, 1'h0);
    sel(8'h0E);
    rdchk(1'h1, 8'h11);
    rdchk(1'h1, 8'h22);
    rdchk(1'h0, 8'hFF);
    sel(8'h00);
    rdchk(1'h0, 8'h33);
    i_mst.stop();
  endtask
  task automatic s_select();
    i_mst.start();
    cmd(8'hA4, 1'h0);
    i_mst.start();
    cmd(8'h5A, 1'h0);
    i_mst.stop();
  endtask
  task automatic s_bank();
    bset(8'h6E, 1'h1);
    i_mst.start();
    cmd(8'h6D, 1'h0);
    rdchk(1'h0, 8'hFF);
    i_mst.start();
    cmd(8'hAA, 1'h1);
    cmd(8'h00, 1'h1);
    cmd(8'h5C, 1'h1);
    i_mst.stop();
    repeat (450) @(posedge ref_clk);
    sel(8'hFF);
    rdchk(1'h1, 8'hFF);
    rdchk(1'h0, 8'h5C);
    i_mst.start();
    cmd(8'hAA, 1'h1);
    cmd(8'h80, 1'h1);
    cmd(8'h99, 1'h0);
    i_mst.stop();
    chb(write_busy, 1'h0);
    bset(8'h6C, 1'h0);
    sel(8'h00);
    rdchk(1'h0, 8'h33);
    i_mst.stop();
  endtask
  task automatic s_timeout();
    sel(8'h00);
    i_mst.hold(400);
    chb(sda_oe, 1'h1);
    chb(sda_out, 1'h0);
    i_mst.hold(10000);
    chb(sda_oe, 1'h0);
    i_mst.stop();
    i_mst.start();
    cmd(8'h6D, 1'h1);
    rdchk(1'h0, 8'hFF);
    i_mst.stop();
  endtask
  initial
  begin
    s_reset();
    s_page_write();
    s_select();
    s_bank();
    s_timeout();
    conclude();
  end
endmodule
`default_nettype wire
